/* File: verif/tb_top.sv */
// Register-level testbench of the UART support block
module tb_top;
    import ubdl_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic         clk_i, rst_i, rx_push, tx_pop, tx_core, rx_pin, stop_mid, wb_ack_o;
    logic         irq, baud, rx_core, tx_o, rts_n, dtr_n, op1_n, op2_n, rxr_n, txr;
    logic         thr_wr, rhr_rd, rx_clr, tx_clr;
    logic [1:0]   flow_evt;
    logic [3:0]   lerr;
    logic [5:0]   rx_cnt, tx_cnt;
    logic [7:0]   rx_byte, rx_data, wb_dat_o, q;
    ubdl_wb_req_s wb;
    ubdl_modem_s  modem;
    int           failures, checks_done, cycles, n;

    ubdl_core ubdl_core_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb), .wb_ack_o(wb_ack_o),
        .wb_dat_o(wb_dat_o), .rx_count_i(rx_cnt), .tx_count_i(tx_cnt), .rx_data_i(rx_data),
        .rx_stop_mid_i(stop_mid), .line_err_i(lerr), .tx_shift_empty_i(1'b1),
        .flow_evt_i(flow_evt), .tx_core_i(tx_core), .rx_i(rx_pin), .modem_i(modem),
        .irq_o(irq), .baud_x16_o(baud), .rx_core_o(rx_core), .tx_o(tx_o), .rts_n_o(rts_n),
        .dtr_n_o(dtr_n), .op1_n_o(op1_n), .op2_n_o(op2_n), .rx_ready_n_o(rxr_n),
        .tx_ready_o(txr), .lcr_o(), .fifo_en_o(), .thr_wr_o(thr_wr), .thr_data_o(),
        .rhr_rd_o(rhr_rd), .rx_fifo_clr_o(rx_clr), .tx_fifo_clr_o(tx_clr));
    ubdl_far_end ubdl_far_end_inst (.clk_i(clk_i), .rst_i(rst_i), .rx_push_i(rx_push),
        .rx_byte_i(rx_byte), .tx_pop_i(tx_pop), .rhr_rd_i(rhr_rd), .thr_wr_i(thr_wr),
        .rx_clr_i(rx_clr), .tx_clr_i(tx_clr), .rx_count_o(rx_cnt), .tx_count_o(tx_cnt),
        .rx_data_o(rx_data), .stop_mid_o(stop_mid));

    always #5 clk_i = ~clk_i;

    task automatic test_done;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done

    // Ceiling well above the longest sequence
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            test_done();
        end
    end

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Classic cycle; no answer latency assumed
    task automatic bus(input logic we, input logic [2:0] a, input logic [7:0] d);
        wb <= '{1'b1, 1'b1, we, a, 1'b1, d};
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        q = wb_dat_o;
        wb <= '0;
        @(posedge clk_i);
    endtask : bus

    task automatic rdc(input string nm, input logic [2:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(nm, {8'h00, e}, {8'h00, q});
    endtask : rdc

    task automatic push(input logic [7:0] b);
        rx_byte <= b;
        rx_push <= 1'b1;
        @(posedge clk_i);
        rx_push <= 1'b0;
        @(posedge clk_i);
    endtask : push

    task automatic pops(input int k);
        repeat (k) begin
            tx_pop <= 1'b1;
            @(posedge clk_i);
        end
        tx_pop <= 1'b0;
        @(posedge clk_i);
    endtask : pops

    initial begin
        clk_i = 0; rst_i = 1; wb = '0; modem = '1; rx_push = 0; tx_pop = 0;
        tx_core = 1; rx_pin = 1; flow_evt = 2'h0; rx_byte = 8'h00; lerr = 4'h0;
        failures = 0; checks_done = 0; cycles = 0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rdc("ier", 3'h1, 8'h00);
        rdc("lcr", 3'h3, 8'h00);
        rdc("isr", 3'h2, 8'h01);
        rdc("unmapped", 3'h7, 8'h00);
        bus(1'b1, 3'h1, 8'h02);
        chk("irq", 16'h0001, {15'h0, irq});
        rdc("isr", 3'h2, 8'h02);
        rdc("isr", 3'h2, 8'h01);
        bus(1'b1, 3'h3, 8'h80);
        bus(1'b1, 3'h1, 8'h01);
        bus(1'b1, 3'h0, 8'h02);
        bus(1'b1, 3'h3, 8'h03);
        rdc("ier", 3'h1, 8'h02);
        while (baud !== 1'b1) @(posedge clk_i);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (baud !== 1'b1);
        chk("baud period", 16'h0102, 16'(n));
        bus(1'b1, 3'h3, 8'h80);
        bus(1'b1, 3'h1, 8'h00);
        bus(1'b1, 3'h0, 8'h01);
        bus(1'b1, 3'h3, 8'h03);
        bus(1'b1, 3'h2, 8'h01);
        push(8'h5a);
        @(negedge clk_i) chk("rx ready", 16'h0000, {15'h0, rxr_n});
        @(posedge clk_i);
        rdc("rx byte", 3'h0, 8'h5a);
        @(negedge clk_i) chk("rx ready", 16'h0001, {15'h0, rxr_n});
        @(posedge clk_i);
        bus(1'b1, 3'h0, 8'h33);
        @(negedge clk_i) chk("tx ready", 16'h0001, {15'h0, txr});
        @(posedge clk_i);
        pops(1);
        @(negedge clk_i) chk("tx ready", 16'h0000, {15'h0, txr});
        @(posedge clk_i);
        bus(1'b1, 3'h1, 8'h01);
        repeat (700) @(posedge clk_i);
        chk("irq", 16'h0000, {15'h0, irq});
        push(8'ha1);
        repeat (300) @(posedge clk_i);
        push(8'ha2);
        repeat (600) @(posedge clk_i);
        chk("irq", 16'h0000, {15'h0, irq});
        repeat (100) @(posedge clk_i);
        chk("irq", 16'h0001, {15'h0, irq});
        rdc("isr", 3'h2, 8'hcc);
        rdc("rx byte", 3'h0, 8'ha1);
        bus(1'b0, 3'h5, 8'h00);
        chk("data ready", 16'h0001, {15'h0, q[0]});
        rdc("rx byte", 3'h0, 8'ha2);
        bus(1'b0, 3'h5, 8'h00);
        chk("data ready", 16'h0000, {15'h0, q[0]});
        rdc("isr", 3'h2, 8'hc1);
        bus(1'b1, 3'h1, 8'hc1);
        flow_evt <= 2'h1;
        @(posedge clk_i);
        flow_evt <= 2'h0;
        for (int i = 0; i < 9; i++) push(8'(i));
        rdc("isr", 3'h2, 8'hc4);
        for (int i = 0; i < 9; i++) rdc("rx byte", 3'h0, 8'(i));
        rdc("isr", 3'h2, 8'he0);
        rdc("isr", 3'h2, 8'hc1);
        bus(1'b1, 3'h1, 8'h06);
        lerr <= 4'h2;
        @(posedge clk_i);
        lerr <= 4'h0;
        rdc("isr", 3'h2, 8'hc6);
        rdc("lsr", 3'h5, 8'he4);
        rdc("isr", 3'h2, 8'hc2);
        bus(1'b1, 3'h1, 8'h00);
        bus(1'b1, 3'h2, 8'h09);
        for (int i = 0; i < 7; i++) push(8'h10);
        @(negedge clk_i) chk("dma rx ready", 16'h0001, {15'h0, rxr_n});
        @(posedge clk_i);
        push(8'h11);
        @(negedge clk_i) chk("dma rx ready", 16'h0000, {15'h0, rxr_n});
        @(posedge clk_i);
        repeat (8) bus(1'b0, 3'h0, 8'h00);
        @(negedge clk_i) chk("dma rx ready", 16'h0001, {15'h0, rxr_n});
        @(posedge clk_i);
        repeat (32) bus(1'b1, 3'h0, 8'h77);
        @(negedge clk_i) chk("dma tx ready", 16'h0001, {15'h0, txr});
        @(posedge clk_i);
        pops(24);
        @(negedge clk_i) chk("dma tx ready", 16'h0001, {15'h0, txr});
        @(posedge clk_i);
        pops(1);
        @(negedge clk_i) chk("dma tx ready", 16'h0000, {15'h0, txr});
        @(posedge clk_i);
        modem <= '0;
        bus(1'b1, 3'h4, 8'h13);
        tx_core <= 1'b0;
        repeat (2) @(posedge clk_i);
        @(negedge clk_i) chk("loop pins", 16'h0003, {13'h0, rx_core, tx_o, rts_n});
        @(posedge clk_i);
        tx_core <= 1'b1;
        bus(1'b0, 3'h6, 8'h00);
        chk("modem status", 16'h0003, {12'h0, q[7:4]});
        bus(1'b1, 3'h1, 8'h08);
        bus(1'b1, 3'h4, 8'h1b);
        rdc("isr", 3'h2, 8'hc0);
        bus(1'b0, 3'h6, 8'h00);
        chk("modem status", 16'h000b, {12'h0, q[7:4]});
        test_done();
    end
endmodule : tb_top

/* File: verif/ubdl_far_end.sv */
// Far-side model: receive and transmit FIFO fills seen by the support block
module ubdl_far_end (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       rx_push_i,
    input  wire logic [7:0] rx_byte_i,
    input  wire logic       tx_pop_i,
    input  wire logic       rhr_rd_i,
    input  wire logic       thr_wr_i,
    input  wire logic       rx_clr_i,
    input  wire logic       tx_clr_i,
    output logic [5:0]      rx_count_o,
    output logic [5:0]      tx_count_o,
    output logic [7:0]      rx_data_o,
    output logic            stop_mid_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem_reg [32];
    logic [4:0] wp_reg;
    logic [4:0] rp_reg;
    logic       rx_in;
    logic       rx_out;
    logic       tx_in;
    logic       tx_out;
    assign rx_in  = rx_push_i && rx_count_o != 6'h20;
    assign rx_out = rhr_rd_i && rx_count_o != 6'h00;
    assign tx_in  = thr_wr_i && tx_count_o != 6'h20;
    assign tx_out = tx_pop_i && tx_count_o != 6'h00;
    // Empty FIFO head is inverted so a stale byte never passes as data
    assign rx_data_o = (rx_count_o == 6'h00) ? ~mem_reg[rp_reg] : mem_reg[rp_reg];
    always_ff @(posedge clk_i) begin
        stop_mid_o <= rx_in;
        if (rst_i || rx_clr_i) begin
            rx_count_o <= 6'h00;
            wp_reg     <= 5'h00;
            rp_reg     <= 5'h00;
        end else begin
            if (rx_in) begin
                mem_reg[wp_reg] <= rx_byte_i;
                wp_reg          <= wp_reg + 5'h01;
            end
            if (rx_out) begin
                rp_reg <= rp_reg + 5'h01;
            end
            rx_count_o <= rx_count_o + {5'h00, rx_in} - {5'h00, rx_out};
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i || tx_clr_i) begin
            tx_count_o <= 6'h00;
        end else begin
            tx_count_o <= tx_count_o + {5'h00, tx_in} - {5'h00, tx_out};
        end
    end
endmodule : ubdl_far_end

/* File: verilog/ubdl_core.sv */
// Interrupt, time-out, baud, DMA-ready and loop-back support for one UART channel
//
// Local design decisions: the Wishbone interface to the registers and the register offsets.
`include "ubdl_regs.svh"

module ubdl_core (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire ubdl_pkg::ubdl_wb_req_s wb_i,
    output logic                       wb_ack_o,
    output logic [7:0]                 wb_dat_o,
    input  wire logic [5:0]            rx_count_i,
    input  wire logic [5:0]            tx_count_i,
    input  wire logic [7:0]            rx_data_i,
    input  wire logic                  rx_stop_mid_i,
    input  wire logic [3:0]            line_err_i,
    input  wire logic                  tx_shift_empty_i,
    input  wire logic [1:0]            flow_evt_i,
    input  wire logic                  tx_core_i,
    input  wire logic                  rx_i,
    input  wire ubdl_pkg::ubdl_modem_s modem_i,
    output logic                       irq_o,
    output logic                       baud_x16_o,
    output logic                       rx_core_o,
    output logic                       tx_o,
    output logic                       rts_n_o,
    output logic                       dtr_n_o,
    output logic                       op1_n_o,
    output logic                       op2_n_o,
    output logic                       rx_ready_n_o,
    output logic                       tx_ready_o,
    output logic [7:0]                 lcr_o,
    output logic                       fifo_en_o,
    output logic                       thr_wr_o,
    output logic [7:0]                 thr_data_o,
    output logic                       rhr_rd_o,
    output logic                       rx_fifo_clr_o,
    output logic                       tx_fifo_clr_o
);
    import ubdl_pkg::*;

    logic [7:0]  ier_reg, fcr_reg, lcr_reg, mcr_reg, dll_reg, dlm_reg, dat_reg, isr_code;
    logic        ack_reg, req, wr, rd, dlab, loop, dma, rx_empty;
    logic        rd_isr, rd_rhr, rd_lsr, rd_msr, wr_thr;
    logic [15:0] divisor, baud_cnt_reg;
    logic        baud_reg;
    logic [5:0]  rx_trig, tx_trig;
    logic [4:0]  chr_bits;
    logic [2:0]  stop_half;
    logic [10:0] to_limit, to_cnt_reg;
    logic        to_pend_reg, thr_pend_reg, tx_was_empty_reg;
    logic [3:0]  lerr_reg, mstat, mstat_prev_reg, mdelta_reg;
    logic [1:0]  flow_reg;
    logic        ls_int, rx_int, to_int, thr_int, ms_int, flow_int;
    logic        rxr_dma_reg, txr_dma_reg;

    function automatic logic [5:0] trig_of(input logic [1:0] sel);
        unique case (sel)
            2'h0: trig_of = 6'h08;
            2'h1: trig_of = 6'h10;
            2'h2: trig_of = 6'h18;
            2'h3: trig_of = 6'h1c;
        endcase
    endfunction : trig_of

    // Classic single cycle: one wait state, ack drops the cycle after
    assign req      = wb_i.cyc & wb_i.stb & ~ack_reg;
    assign wr       = req & wb_i.we & wb_i.sel;
    assign rd       = req & ~wb_i.we;
    assign dlab     = lcr_reg[`UBDL_LCR_DLAB];
    assign loop     = mcr_reg[`UBDL_MCR_LOOP];
    assign dma      = fcr_reg[`UBDL_FCR_DMA];
    assign rx_empty = (rx_count_i == 6'h00);
    assign rd_isr   = rd & (wb_i.adr == `UBDL_ADR_ISR_FCR);
    assign rd_rhr   = rd & (wb_i.adr == `UBDL_ADR_DATA) & ~dlab;
    assign rd_lsr   = rd & (wb_i.adr == `UBDL_ADR_LSR);
    assign rd_msr   = rd & (wb_i.adr == `UBDL_ADR_MSR);
    assign wr_thr   = wr & (wb_i.adr == `UBDL_ADR_DATA) & ~dlab;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ier_reg <= `UBDL_IER_RST;
            fcr_reg <= `UBDL_FCR_RST;
            lcr_reg <= `UBDL_LCR_RST;
            mcr_reg <= `UBDL_MCR_RST;
            dll_reg <= 8'(`UBDL_DIV_RST);
            dlm_reg <= 8'(`UBDL_DIV_RST >> 8);
        end else if (wr) begin
            unique case (wb_i.adr)
                `UBDL_ADR_DATA: begin
                    if (dlab) dll_reg <= wb_i.dat;
                end
                `UBDL_ADR_IER: begin
                    if (dlab) dlm_reg <= wb_i.dat;
                    else ier_reg <= wb_i.dat;
                end
                `UBDL_ADR_ISR_FCR: fcr_reg <= {wb_i.dat[7:3], 2'b00, wb_i.dat[0]};
                `UBDL_ADR_LCR:     lcr_reg <= wb_i.dat;
                `UBDL_ADR_MCR:     mcr_reg <= {3'b000, wb_i.dat[4:0]};
                default: ;
            endcase
        end
    end

    // Strobes and write data toward the FIFOs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            thr_wr_o      <= 1'b0;
            thr_data_o    <= 8'h00;
            rhr_rd_o      <= 1'b0;
            rx_fifo_clr_o <= 1'b0;
            tx_fifo_clr_o <= 1'b0;
        end else begin
            thr_wr_o      <= wr_thr;
            rhr_rd_o      <= rd_rhr;
            rx_fifo_clr_o <= wr & (wb_i.adr == `UBDL_ADR_ISR_FCR) & wb_i.dat[`UBDL_FCR_RXCLR];
            tx_fifo_clr_o <= wr & (wb_i.adr == `UBDL_ADR_ISR_FCR) & wb_i.dat[`UBDL_FCR_TXCLR];
            if (wr_thr) thr_data_o <= wb_i.dat;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_reg <= 8'h00;
        end else if (rd) begin
            unique case (wb_i.adr)
                `UBDL_ADR_DATA:    dat_reg <= dlab ? dll_reg : rx_data_i;
                `UBDL_ADR_IER:     dat_reg <= dlab ? dlm_reg : ier_reg;
                `UBDL_ADR_ISR_FCR: dat_reg <= isr_code;
                `UBDL_ADR_LCR:     dat_reg <= lcr_reg;
                `UBDL_ADR_MCR:     dat_reg <= mcr_reg;
                `UBDL_ADR_LSR:     dat_reg <= {|lerr_reg, tx_shift_empty_i & (tx_count_i == 6'h00),
                                               tx_count_i == 6'h00, lerr_reg, ~rx_empty};
                `UBDL_ADR_MSR:     dat_reg <= {mstat[2], mstat[3], mstat[1], mstat[0],
                                               mdelta_reg[2], mdelta_reg[3], mdelta_reg[1:0]};
                default:           dat_reg <= 8'h00;
            endcase
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign lcr_o    = lcr_reg;
    assign fifo_en_o = fcr_reg[`UBDL_FCR_EN];

    // Baud generator, one tick per divisor input clocks
    assign divisor = {dlm_reg, dll_reg};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            baud_cnt_reg <= 16'h0000;
            baud_reg     <= 1'b0;
        end else if (divisor == 16'h0000) begin
            // Divisor zero is outside the legal range; generator parks
            baud_cnt_reg <= 16'h0000;
            baud_reg     <= 1'b0;
        end else if (baud_cnt_reg >= divisor - 16'h0001) begin
            baud_cnt_reg <= 16'h0000;
            baud_reg     <= 1'b1;
        end else begin
            baud_cnt_reg <= baud_cnt_reg + 16'h0001;
            baud_reg     <= 1'b0;
        end
    end

    assign baud_x16_o = baud_reg;

    // Receive time-out, counted in 16x ticks
    assign chr_bits  = 5'h06 + {3'b000, lcr_reg[1:0]} + {4'h0, lcr_reg[`UBDL_LCR_PAR]};
    assign stop_half = !lcr_reg[`UBDL_LCR_STOP] ? 3'h2 : (lcr_reg[1:0] == 2'b00 ? 3'h3 : 3'h4);
    assign to_limit  = ({6'h00, chr_bits} * 11'h002 + {8'h00, stop_half})
                       * {7'h00, `UBDL_TICKS_HALF} * {8'h00, `UBDL_TO_CHARS};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            to_cnt_reg <= 11'h000;
        end else if (rx_stop_mid_i || rd_rhr || rx_empty) begin
            to_cnt_reg <= 11'h000;
        end else if (baud_reg && to_cnt_reg < to_limit) begin
            to_cnt_reg <= to_cnt_reg + 11'h001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            to_pend_reg <= 1'b0;
        end else if (rx_empty) begin
            to_pend_reg <= 1'b0;
        end else if (baud_reg && to_cnt_reg == to_limit - 11'h001) begin
            to_pend_reg <= 1'b1;
        end else if (rd_rhr) begin
            to_pend_reg <= 1'b0;
        end
    end

    // Pending starts set so that enabling it after reset raises it at once
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            thr_pend_reg     <= 1'b1;
            tx_was_empty_reg <= 1'b1;
        end else begin
            tx_was_empty_reg <= (tx_count_i == 6'h00);
            if (tx_count_i == 6'h00 && !tx_was_empty_reg) begin
                thr_pend_reg <= 1'b1;
            end else if (wr_thr || (rd_isr && isr_code[5:0] == 6'(`UBDL_ISR_THR))) begin
                thr_pend_reg <= 1'b0;
            end
        end
    end

    // Sticky flags: a new event in the clearing cycle survives
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lerr_reg <= 4'h0;
        end else begin
            lerr_reg <= (rd_lsr ? 4'h0 : lerr_reg) | line_err_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flow_reg <= 2'b00;
        end else if (rd_isr && isr_code[5:0] == 6'(`UBDL_ISR_FLOW)) begin
            flow_reg <= flow_evt_i;
        end else begin
            flow_reg <= flow_reg | flow_evt_i;
        end
    end

    // Modem inputs, rerouted from own outputs during loop-back
    always_comb begin
        if (loop) begin
            mstat[0] = mcr_reg[`UBDL_MCR_RTS];
            mstat[1] = mcr_reg[`UBDL_MCR_DTR];
            mstat[2] = mcr_reg[`UBDL_MCR_OP2];
            mstat[3] = mcr_reg[`UBDL_MCR_OP1];
        end else begin
            mstat[0] = ~modem_i.cts_n;
            mstat[1] = ~modem_i.dsr_n;
            mstat[2] = ~modem_i.cd_n;
            mstat[3] = ~modem_i.ri_n;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mstat_prev_reg <= 4'h0;
            mdelta_reg     <= 4'h0;
        end else begin
            mstat_prev_reg <= mstat;
            mdelta_reg     <= (rd_msr ? 4'h0 : mdelta_reg) | (mstat ^ mstat_prev_reg);
        end
    end

    assign rx_trig = trig_of(fcr_reg[7:6]);
    assign tx_trig = trig_of(fcr_reg[5:4]);

    assign ls_int   = ier_reg[`UBDL_IER_LS] & (|lerr_reg);
    assign rx_int   = ier_reg[`UBDL_IER_RX] & (fcr_reg[`UBDL_FCR_EN] ?
                      (rx_count_i >= rx_trig) : !rx_empty);
    assign to_int   = ier_reg[`UBDL_IER_RX] & to_pend_reg;
    assign thr_int  = ier_reg[`UBDL_IER_THR] & thr_pend_reg;
    assign ms_int   = ier_reg[`UBDL_IER_MS] & (|mdelta_reg);
    assign flow_int = (ier_reg[`UBDL_IER_CTS] & flow_reg[0]) | (ier_reg[`UBDL_IER_RTS] & flow_reg[1]);

    // Only one source is ever visible; flow control last
    always_comb begin
        if (ls_int)        isr_code = `UBDL_ISR_LS;
        else if (rx_int)   isr_code = `UBDL_ISR_RX;
        else if (to_int)   isr_code = `UBDL_ISR_TO;
        else if (thr_int)  isr_code = `UBDL_ISR_THR;
        else if (ms_int)   isr_code = `UBDL_ISR_MS;
        else if (flow_int) isr_code = `UBDL_ISR_FLOW;
        else               isr_code = `UBDL_ISR_NONE;
        if (fcr_reg[`UBDL_FCR_EN]) isr_code = isr_code | `UBDL_ISR_FIFO;
    end

    assign irq_o = ~isr_code[0];

    // DMA-mode ready levels are tracked continuously
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rxr_dma_reg <= 1'b1;
        end else if (rx_empty) begin
            rxr_dma_reg <= 1'b1;
        end else if (rx_count_i >= rx_trig || to_pend_reg) begin
            rxr_dma_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            txr_dma_reg <= 1'b0;
        end else if (tx_count_i == `UBDL_FIFO_FULL) begin
            txr_dma_reg <= 1'b1;
        end else if (tx_count_i < tx_trig) begin
            txr_dma_reg <= 1'b0;
        end
    end

    assign rx_ready_n_o = dma ? rxr_dma_reg : rx_empty;
    assign tx_ready_o   = dma ? txr_dma_reg : (tx_count_i != 6'h00);

    // Pins and serial path; loop-back parks outputs inactive
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_o      <= 1'b1;
            rx_core_o <= 1'b1;
            rts_n_o   <= 1'b1;
            dtr_n_o   <= 1'b1;
            op1_n_o   <= 1'b1;
            op2_n_o   <= 1'b1;
        end else begin
            tx_o      <= loop ? 1'b1 : tx_core_i;
            rx_core_o <= loop ? tx_core_i : rx_i;
            rts_n_o   <= loop | ~mcr_reg[`UBDL_MCR_RTS];
            dtr_n_o   <= loop | ~mcr_reg[`UBDL_MCR_DTR];
            op1_n_o   <= loop | ~mcr_reg[`UBDL_MCR_OP1];
            op2_n_o   <= loop | ~mcr_reg[`UBDL_MCR_OP2];
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_thr_after_reset;
        $fell(rst_i) |-> thr_pend_reg;
    endproperty
    a_thr_after_reset: assert property (p_thr_after_reset) else $error("no thr pending");
    property p_ls_first;
        ls_int |-> isr_code[5:0] == 6'(`UBDL_ISR_LS);
    endproperty
    a_ls_first: assert property (p_ls_first) else $error("line status not top");
    property p_flow_hidden;
        (flow_int && (ms_int || thr_int || rx_int)) |-> isr_code[5:0] != 6'(`UBDL_ISR_FLOW);
    endproperty
    a_flow_hidden: assert property (p_flow_hidden) else $error("flow not lowest");
    property p_to_empty;
        rx_empty |=> !to_pend_reg;
    endproperty
    a_to_empty: assert property (p_to_empty) else $error("timeout while empty");
    property p_to_restart;
        (rx_stop_mid_i || rd_rhr) |=> to_cnt_reg == 11'h000;
    endproperty
    a_to_restart: assert property (p_to_restart) else $error("timeout not restarted");
    property p_baud_gap;
        (baud_reg && divisor > 16'h0001 && wr == 1'b0) |=> !baud_reg;
    endproperty
    a_baud_gap: assert property (p_baud_gap) else $error("baud tick too close");
    property p_rxr_dma_empty;
        (dma && rx_empty) |=> (rx_ready_n_o || !dma);
    endproperty
    a_rxr_dma_empty: assert property (p_rxr_dma_empty) else $error("rx ready low on empty");
    property p_txr_full;
        (tx_count_i == `UBDL_FIFO_FULL) |=> txr_dma_reg;
    endproperty
    a_txr_full: assert property (p_txr_full) else $error("tx ready not set at full");
    property p_loop_path;
        (loop && $stable(loop)) |=> (rx_core_o == $past(tx_core_i)) && tx_o;
    endproperty
    a_loop_path: assert property (p_loop_path) else $error("loop-back path broken");
    property p_ack_single;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_single: assert property (p_ack_single) else $error("ack held two cycles");

endmodule : ubdl_core

/* File: verilog/ubdl_pkg.sv */
// Shared types of the UART support block
package ubdl_pkg;
    typedef struct packed {
        logic       cyc;
        logic       stb;
        logic       we;
        logic [2:0] adr;
        logic       sel;
        logic [7:0] dat;
    } ubdl_wb_req_s;

    typedef struct packed {
        logic cts_n;
        logic dsr_n;
        logic cd_n;
        logic ri_n;
    } ubdl_modem_s;
endpackage : ubdl_pkg

/* File: verilog/ubdl_regs.svh */
// Register offsets, bit positions, reset values and counts for the UART support block
`ifndef UBDL_REGS_SVH
`define UBDL_REGS_SVH

`define UBDL_ADR_DATA    3'h0
`define UBDL_ADR_IER     3'h1
`define UBDL_ADR_ISR_FCR 3'h2
`define UBDL_ADR_LCR     3'h3
`define UBDL_ADR_MCR     3'h4
`define UBDL_ADR_LSR     3'h5
`define UBDL_ADR_MSR     3'h6

`define UBDL_IER_RX      0
`define UBDL_IER_THR     1
`define UBDL_IER_LS      2
`define UBDL_IER_MS      3
`define UBDL_IER_RTS     6
`define UBDL_IER_CTS     7
`define UBDL_FCR_EN      0
`define UBDL_FCR_RXCLR   1
`define UBDL_FCR_TXCLR   2
`define UBDL_FCR_DMA     3
`define UBDL_LCR_PAR     3
`define UBDL_LCR_STOP    2
`define UBDL_LCR_DLAB    7
`define UBDL_MCR_DTR     0
`define UBDL_MCR_RTS     1
`define UBDL_MCR_OP1     2
`define UBDL_MCR_OP2     3
`define UBDL_MCR_LOOP    4

`define UBDL_IER_RST     8'h00
`define UBDL_FCR_RST     8'h00
`define UBDL_LCR_RST     8'h00
`define UBDL_MCR_RST     8'h00
`define UBDL_DIV_RST     16'h0000

`define UBDL_ISR_NONE    8'h01
`define UBDL_ISR_LS      8'h06
`define UBDL_ISR_RX      8'h04
`define UBDL_ISR_TO      8'h0c
`define UBDL_ISR_THR     8'h02
`define UBDL_ISR_MS      8'h00
`define UBDL_ISR_FLOW    8'h20
`define UBDL_ISR_FIFO    8'hc0

`define UBDL_FIFO_FULL   6'h20
`define UBDL_TICKS_HALF  4'h8
`define UBDL_TO_CHARS    3'h4
`endif
